//--- pkg/rsl_consts.vh
// Purpose: constants for the rail sequence timestamp log
// Assumes: 100 MHz clk_sys, byte-wide register read port
// Notes: offsets are byte addresses on the register read port
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register map: high byte then low byte per channel, from channel 4 upward
`define RSL_ADDR_BASE 8'h96
`define RSL_ADDR_HIGH_CH4 8'h96
`define RSL_ADDR_LOW_CH4 8'h97
`define RSL_ADDR_HIGH_CH5 8'h98
`define RSL_ADDR_LOW_CH5 8'h99
`define RSL_ADDR_HIGH_CH6 8'h9a
`define RSL_ADDR_LOW_CH6 8'h9b
`define RSL_READ_UNMAPPED 8'h00

////////////////////////////////////////////////////////////////////////////////
// fields and reset values
`define RSL_STAMP_W 16
`define RSL_FIELD_MSB 7
`define RSL_FIELD_LSB 0
`define RSL_STAMP_RESET 16'h0000
`define RSL_TIMER_MAX 16'hffff

////////////////////////////////////////////////////////////////////////////////
// request codes of the power-state and sleep request fields
`define RSL_REQ_UP 2'b01
`define RSL_REQ_DOWN 2'b10

// sequence modes
`define RSL_MODE_IDLE 2'b00
`define RSL_MODE_UP 2'b01
`define RSL_MODE_DOWN 2'b10

////////////////////////////////////////////////////////////////////////////////
// timing
`define RSL_CLK_PERIOD_NS 10
`define RSL_STAMP_UNIT_TIME_NS 50000
`define RSL_TICK_CYCLES (`RSL_STAMP_UNIT_TIME_NS / `RSL_CLK_PERIOD_NS)

`endif

//--- core/rsl_seq_stamp.v
// Purpose: per-channel sequence timestamp capture for channels 4 to 6
// Assumes: comparator levels and request fields are synchronous to clk_sys
// Notes: a rail already past its threshold at sequence start gets no stamp
// Notes: stamps keep their value across sequences until that channel captures again
// Notes: a held request field does not retrigger; only a change into 01 or 10 does
`include "rsl_consts.vh"

// Contract
// - each channel holds a read-only 16-bit stamp as high and low byte registers
// - the stamp is the sequence timer count during a requested sequence
// - in a 01 sequence, stamp when the rail rises past its undervoltage threshold
// - in a 10 sequence, stamp when the rail falls past the 200mV off threshold
// - one timer count, the stamp's lowest bit, equals 50us
module rsl_seq_stamp #(
	parameter NUM_CH = 3,
	parameter TICK_CYCLES = `RSL_TICK_CYCLES
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// sequence trigger fields
	input wire [1:0] power_state_request,
	input wire [1:0] sleep_request,
	// comparator levels per channel
	input wire [NUM_CH-1:0] rail_above_uv,
	input wire [NUM_CH-1:0] rail_below_off,
	// register read port
	input wire rd_en,
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data_q,
	output reg rd_valid_q,
	// sequence status
	output reg [1:0] seq_mode_q,
	output reg [`RSL_STAMP_W-1:0] seq_timer_q,
	output reg [NUM_CH-1:0] stamp_done_q
);

	// integer forms first, then cut to the register widths on purpose
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam integer MAP_BYTES_I = 2 * NUM_CH;
	localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
	localparam [7:0] MAP_BYTES = MAP_BYTES_I[7:0];

	////////////////////////////////////////////////////////////////////////////
	// trigger detection
	reg [1:0] ps_prev_q;
	reg [1:0] sl_prev_q;
	reg [NUM_CH-1:0] uv_prev_q;
	reg [NUM_CH-1:0] off_prev_q;
	reg [15:0] tick_cnt_q;
	reg [`RSL_STAMP_W-1:0] stamp_q [0:NUM_CH-1];
	wire start_up;
	wire start_down;
	wire start_any;
	wire tick;
	wire [NUM_CH-1:0] capture;
	wire all_done;
	wire seq_active;
	// per-field request edges
	wire ps_up;
	wire ps_down;
	wire sl_up;
	wire sl_down;
	// per-channel edges and byte views
	wire [NUM_CH-1:0] rise_uv;
	wire [NUM_CH-1:0] fall_off;
	wire [8*NUM_CH-1:0] hi_byte;
	wire [8*NUM_CH-1:0] lo_byte;

	// a field counts as a new request only on the cycle it takes the code;
	// previous values reset to 00, so a field already set at release triggers
	assign ps_up = (power_state_request == `RSL_REQ_UP) && (ps_prev_q != `RSL_REQ_UP);
	assign ps_down = (power_state_request == `RSL_REQ_DOWN) && (ps_prev_q != `RSL_REQ_DOWN);
	assign sl_up = (sleep_request == `RSL_REQ_UP) && (sl_prev_q != `RSL_REQ_UP);
	assign sl_down = (sleep_request == `RSL_REQ_DOWN) && (sl_prev_q != `RSL_REQ_DOWN);
	// power-state and sleep requests open the same two kinds of sequence
	assign start_up = ps_up | sl_up;
	assign start_down = ps_down | sl_down;
	assign start_any = start_up | start_down;
	assign tick = (tick_cnt_q == TICK_LAST);
	assign seq_active = (seq_mode_q != `RSL_MODE_IDLE);
	// ends the sequence on the same edge as the last capture
	assign all_done = &(stamp_done_q | capture);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ps_prev_q <= 2'h0;
			sl_prev_q <= 2'h0;
			uv_prev_q <= {NUM_CH{1'b0}};
			off_prev_q <= {NUM_CH{1'b0}};
		end else begin
			ps_prev_q <= power_state_request;
			sl_prev_q <= sleep_request;
			uv_prev_q <= rail_above_uv;
			off_prev_q <= rail_below_off;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequence mode and timer
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			seq_mode_q <= `RSL_MODE_IDLE;
		end else if (start_down) begin
			// power-down wins a tie: a rail going off matters more than one coming up
			seq_mode_q <= `RSL_MODE_DOWN;
		end else if (start_up) begin
			seq_mode_q <= `RSL_MODE_UP;
		end else if (seq_active && all_done) begin
			seq_mode_q <= `RSL_MODE_IDLE;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			tick_cnt_q <= 16'h0000;
			seq_timer_q <= `RSL_STAMP_RESET;
		end else if (start_any) begin
			tick_cnt_q <= 16'h0000;
			seq_timer_q <= `RSL_STAMP_RESET;
		end else if (seq_active) begin
			// the prescaler only runs inside a sequence, so idle costs no toggling
			if (tick) begin
				tick_cnt_q <= 16'h0000;
				// saturate rather than wrap so a late rail never looks early
				if (seq_timer_q != `RSL_TIMER_MAX) begin
					seq_timer_q <= seq_timer_q + 16'h0001;
				end
			end else begin
				tick_cnt_q <= tick_cnt_q + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel capture
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
			// edge of the comparator level since the previous clock
			assign rise_uv[gi] = rail_above_uv[gi] && !uv_prev_q[gi];
			assign fall_off[gi] = rail_below_off[gi] && !off_prev_q[gi];

			// a trigger edge restarts the sequence, so it never stamps as well
			assign capture[gi] = !stamp_done_q[gi] && !start_any && (
				((seq_mode_q == `RSL_MODE_UP) && rise_uv[gi]) ||
				((seq_mode_q == `RSL_MODE_DOWN) && fall_off[gi]));

			// byte views of the stamp for the read mux
			assign hi_byte[8*gi +: 8] = stamp_q[gi][`RSL_STAMP_W-1:`RSL_FIELD_MSB+1];
			assign lo_byte[8*gi +: 8] = stamp_q[gi][`RSL_FIELD_MSB:`RSL_FIELD_LSB];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// stamp storage: one process so every flag and stamp has a single driver
	integer si;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			for (si = 0; si < NUM_CH; si = si + 1) begin
				stamp_q[si] <= `RSL_STAMP_RESET;
			end
			stamp_done_q <= {NUM_CH{1'b0}};
		end else if (start_any) begin
			// stamps survive a retrigger; only the done flags clear
			stamp_done_q <= {NUM_CH{1'b0}};
		end else begin
			for (si = 0; si < NUM_CH; si = si + 1) begin
				if (capture[si]) begin
					stamp_q[si] <= seq_timer_q;
					stamp_done_q[si] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read port: high byte at even offset, low byte at odd offset
	// there is no shadow latch: a capture landing between the two byte reads
	// can tear the value, so software should read while idle or read twice
	wire [7:0] rd_off;
	wire rd_in_map;
	reg [7:0] rd_byte;
	integer ci;

	// addresses below the base wrap to large offsets and fall out of the map
	assign rd_off = rd_addr - `RSL_ADDR_BASE;
	assign rd_in_map = (rd_off < MAP_BYTES);

	always @* begin
		rd_byte = `RSL_READ_UNMAPPED;
		for (ci = 0; ci < NUM_CH; ci = ci + 1) begin
			if (rd_in_map && rd_off[7:1] == ci[6:0]) begin
				if (rd_off[0]) begin
					rd_byte = lo_byte[8*ci +: 8];
				end else begin
					rd_byte = hi_byte[8*ci +: 8];
				end
			end
		end
	end

	// no write path: the stamps are read-only by construction
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data_q <= `RSL_READ_UNMAPPED;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
			if (rd_en) begin
				rd_data_q <= rd_byte;
			end
		end
	end

endmodule

//--- tb/rsl_seq_stamp_properties.sv
// Purpose: checks on stamp log ports
// Assumes: request fields idle in reset
// Notes: timer may stop when idle
module rsl_seq_stamp_properties #(parameter NUM_CH = 3, parameter TICK_CYCLES = 4) (
	input wire clk_sys, rst_n, rd_en, rd_valid_q,
	input wire [1:0] power_state_request, sleep_request, seq_mode_q,
	input wire [NUM_CH-1:0] rail_above_uv, rail_below_off, stamp_done_q,
	input wire [7:0] rd_addr, rd_data_q,
	input wire [15:0] seq_timer_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pf;
	always @(posedge clk_sys) pf <= {power_state_request, sleep_request};
	// odd parity picks 01 or 10; a held code is no new trigger
	wire tr = (^power_state_request && power_state_request != pf[3:2])
		|| (^sleep_request && sleep_request != pf[1:0]);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_rv; rd_en |=> rd_valid_q; endproperty
	a_rv: assert property (p_rv) else $error("no answer");
	property p_um; rd_en && rd_addr > 8'h9b |=> rd_data_q == 8'h00; endproperty
	a_um: assert property (p_um) else $error("unmapped");
	property p_tr; tr |=> seq_timer_q == 0 && stamp_done_q == 0; endproperty
	a_tr: assert property (p_tr) else $error("no restart");
	property p_inc; $changed(seq_timer_q) |-> seq_timer_q == 0
		|| seq_timer_q == $past(seq_timer_q) + 16'h0001; endproperty
	a_inc: assert property (p_inc) else $error("timer jump");
	property p_up; seq_mode_q == 2'b01 && $rose(rail_above_uv[0]) && !stamp_done_q[0]
		&& !tr |=> stamp_done_q[0]; endproperty
	a_up: assert property (p_up) else $error("no stamp");
	property p_dn; seq_mode_q == 2'b10 && $rose(rail_below_off[2]) && !stamp_done_q[2]
		&& !tr |=> stamp_done_q[2]; endproperty
	a_dn: assert property (p_dn) else $error("no off stamp");
	property p_end; &stamp_done_q && seq_mode_q != 0 && !tr |=> seq_mode_q == 0; endproperty
	a_end: assert property (p_end) else $error("no end");
endmodule
bind rsl_seq_stamp rsl_seq_stamp_properties #(.NUM_CH(NUM_CH), .TICK_CYCLES(TICK_CYCLES))
	u_props (.*);

//--- tb/tb_rsl_seq_stamp.sv
// Purpose: random sequences and readback
// Assumes: TICK_CYCLES of 4
// Notes: rails cross once per sequence
module tb_rsl_seq_stamp;
	timeunit 1ns;
	timeprecision 1ns;
	localparam TK = 4;
	logic clk_sys = 0, rst_n = 0, rd_en = 0, rd_valid_q;
	logic [1:0] power_state_request = 0, sleep_request = 0, seq_mode_q;
	logic [2:0] rail_above_uv = 0, rail_below_off = 0, stamp_done_q;
	logic [7:0] rd_addr = 0, rd_data_q;
	logic [15:0] seq_timer_q, ex [3];
	int fails = 0, check_count = 0, n, d;
	rsl_seq_stamp #(.TICK_CYCLES(TK)) u_rsl_seq_stamp (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task tick; @(posedge clk_sys); #1; endtask
	function int stamp(int c); return c / TK; endfunction
	task chk(logic [7:0] g, e);
		check_count++;
		if (g !== e) begin
			$display("Error %0t: read %h not %h", $time, g, e);
			fails++;
		end
	endtask
	task chk_st(logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			$display("Error %0t: status %h not %h", $time, g, e);
			fails++;
		end
	endtask
	task rd(logic [7:0] a, e);
		rd_en = 1;
		rd_addr = a;
		tick;
		chk_st(rd_valid_q, 1);
		chk(rd_data_q, e);
	endtask
	task finish_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hcc63a55f));
		repeat (2) tick;
		rst_n = 1;
		for (int a = 8'h95; a < 8'h9d; a++) rd(a, 8'h00);
		rd_en = 0;
		$display("reset done");
		for (int k = 0; k < 4; k++) begin
			{power_state_request, sleep_request, rail_above_uv, rail_below_off} = 0;
			tick;
			if (k[1]) sleep_request = k[0] ? 2'b10 : 2'b01;
			else power_state_request = k[0] ? 2'b10 : 2'b01;
			tick;
			chk_st(seq_mode_q, k[0] ? 2'b10 : 2'b01);
			chk_st(seq_timer_q, 0);
			n = 0;
			for (int c = 0; c < 3; c++) begin
				d = (k + c == 0) ? 0 : $urandom_range(1, 900);
				repeat (d) tick;
				n += d;
				ex[c] = stamp(n);
				if (k[0]) rail_below_off[c] = 1;
				else rail_above_uv[c] = 1;
			end
			for (d = 0; d < 9 && seq_mode_q !== 2'b00; d++) tick;
			if (d == 9) begin
				fails++;
				finish_test;
			end
			chk_st(stamp_done_q, 3'b111);
			for (int r = 0; r < 6; r++) rd(8'h96 + r, ex[r / 2] >> (r[0] ? 0 : 8));
			rd_en = 0;
			$display("sequence %0d done", k);
		end
		{power_state_request, sleep_request, rail_above_uv, rail_below_off} = 0;
		tick;
		power_state_request = 2'b01;
		sleep_request = 2'b10;
		tick;
		chk_st(seq_mode_q, 2'b10);
		repeat (7) tick;
		power_state_request = 2'b00;
		tick;
		power_state_request = 2'b10;
		tick;
		chk_st(seq_timer_q, 0);
		chk_st(stamp_done_q, 0);
		$display("tie and retrigger done");
		finish_test;
	end
endmodule
